// >>> hdl/bdcp_pkg.sv
`default_nettype none
package bdcp_pkg;
  // Serial field widths.
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;
  // Link timing in debug clock cycles; the bit-slot values count from the perceived start.
  localparam logic [4:0] DLY_CYC = 5'h10;
  localparam logic [4:0] SAMPLE_CYC = 5'h0a;
  localparam logic [4:0] ONE_PULSE_CYC = 5'h07;
  localparam logic [4:0] ZERO_LOW_CYC = 5'h0d;
  localparam logic [7:0] SYNC_DET_CYC = 8'h80;
  localparam logic [7:0] SYNC_GAP_CYC = 8'h10;
  localparam logic [7:0] SYNC_LOW_CYC = 8'h80;
  localparam logic [9:0] TIMEOUT_CYC = 10'h200;
  // Command codes.
  localparam logic [7:0] CMD_ACK_ON = 8'hd5;
  localparam logic [7:0] CMD_ACK_OFF = 8'hd6;
  localparam logic [7:0] CMD_BGND = 8'h90;
  localparam logic [7:0] CMD_STAT_RD = 8'he4;
  localparam logic [7:0] CMD_CTRL_WR = 8'hc4;
  localparam logic [7:0] CMD_MEM_RD = 8'he0;
  localparam logic [7:0] CMD_MEM_RD_S = 8'he1;
  localparam logic [7:0] CMD_MEM_LAST = 8'he8;
  localparam logic [7:0] CMD_MEM_WR = 8'hc0;
  localparam logic [7:0] CMD_MEM_WR_S = 8'hc1;
  localparam logic [7:0] CMD_MATCH_RD = 8'he2;
  localparam logic [7:0] CMD_MATCH_WR = 8'hc2;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_RESUME_TAGGING_CMD = 8'h18;
  localparam logic [7:0] CMD_RD_ACC = 8'h68;
  localparam logic [7:0] CMD_RD_CCR = 8'h69;
  localparam logic [7:0] CMD_RD_PC = 8'h6b;
  localparam logic [7:0] CMD_RD_HX = 8'h6c;
  localparam logic [7:0] CMD_RD_SP = 8'h6f;
  localparam logic [7:0] CMD_NEXT_RD = 8'h70;
  localparam logic [7:0] CMD_NEXT_RD_S = 8'h71;
  localparam logic [7:0] CMD_WR_ACC = 8'h48;
  localparam logic [7:0] CMD_WR_CCR = 8'h49;
  localparam logic [7:0] CMD_WR_PC = 8'h4b;
  localparam logic [7:0] CMD_WR_HX = 8'h4c;
  localparam logic [7:0] CMD_WR_SP = 8'h4f;
  localparam logic [7:0] CMD_NEXT_WR = 8'h50;
  localparam logic [7:0] CMD_NEXT_WR_S = 8'h51;
  // Status and control byte layout.
  localparam int SR_ENTRY = 7;
  localparam int SR_HALTED = 6;
  localparam int SR_BRK_EN = 5;
  localparam int SR_FTS = 4;
  localparam int SR_CLKSW = 3;
  localparam logic [7:0] SR_WMASK = 8'hb8;
  localparam logic [7:0] SR_RESET = 8'h00;
  // Wishbone map.
  localparam logic [3:0] WB_CTRL_OFS = 4'h0;
  localparam logic [3:0] WB_STAT_OFS = 4'h4;
  localparam int CTRL_LINK_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  typedef enum logic [2:0] {
    REG_ACC, REG_CCR, REG_PC, REG_HX, REG_SP
  } bdcp_reg_e;
endpackage
`default_nettype wire

// >>> hdl/bdcp_bit_link.sv
`timescale 1ns/10ps
`default_nettype none
module bdcp_bit_link (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic busy_i,
  input wire logic tx_en_i,
  input wire logic tx_bit_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic rx_valid_o,
  output logic rx_bit_o,
  output logic slot_done_o,
  output logic sync_o,
  output logic timeout_o
);
  typedef enum logic [1:0] {SY_IDLE, SY_GAP, SY_LOW, SY_HIGH} bdcp_sy_e;
  bdcp_sy_e sy_q;
  logic s1_q, s2_q, s3_q;
  logic active_q, txmode_q, txbit_q;
  logic [4:0] cnt_q, cnt_d;
  logic active_d;
  logic [7:0] low_q, scnt_q;
  logic [9:0] gap_q;
  logic out_q, oe_n_q;
  logic fall_w, slot_end_w, drv_low_d, drv_high_d;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Our own drive must never look like a host edge.
  assign fall_w = s3_q & ~s2_q & oe_n_q & enable_i & (sy_q == SY_IDLE);
  assign slot_end_w = active_q & (cnt_q == bdcp_pkg::ZERO_LOW_CYC);
  assign active_d = fall_w ? 1'b1 : (slot_end_w ? 1'b0 : active_q);
  assign cnt_d = fall_w ? 5'h00 : cnt_q + 5'h01;
  assign rx_valid_o = active_q & ~txmode_q
    & (cnt_q == bdcp_pkg::SAMPLE_CYC);
  assign rx_bit_o = s2_q;
  assign slot_done_o = active_q & txmode_q
    & (cnt_q == bdcp_pkg::SAMPLE_CYC);
  // Zero: low from the start for 13 cycles, then a speedup pulse.
  assign drv_low_d = active_d & (fall_w ? tx_en_i & ~tx_bit_i
    : txmode_q & ~txbit_q & (cnt_d < bdcp_pkg::ZERO_LOW_CYC));
  assign drv_high_d = active_d & ~fall_w & txmode_q & (txbit_q
    ? cnt_d == bdcp_pkg::ONE_PULSE_CYC
    : cnt_d == bdcp_pkg::ZERO_LOW_CYC);
  assign sync_o = (sy_q == SY_IDLE) & s2_q
    & (low_q == bdcp_pkg::SYNC_DET_CYC);
  assign timeout_o = busy_i & (gap_q == bdcp_pkg::TIMEOUT_CYC);
  assign pin_o = out_q;
  assign pin_oe_n_o = oe_n_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || sync_o) begin
      active_q <= 1'b0;
      cnt_q <= 5'h00;
      txmode_q <= 1'b0;
      txbit_q <= 1'b0;
    end else begin
      active_q <= active_d;
      cnt_q <= cnt_d;
      if (fall_w) begin
        txmode_q <= tx_en_i;
        txbit_q <= tx_bit_i;
      end
    end
  end

  // Idle time between host edges; a stalled host abandons the command.
  always_ff @(posedge clk_i) begin
    if (rst_i || fall_w) begin
      gap_q <= 10'h000;
    end else if (gap_q != bdcp_pkg::TIMEOUT_CYC) begin
      gap_q <= gap_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A host low far longer than any bit asks for the timed reply.
  always_ff @(posedge clk_i) begin
    if (rst_i || s2_q || !oe_n_q || !enable_i) begin
      low_q <= 8'h00;
    end else if (low_q != bdcp_pkg::SYNC_DET_CYC) begin
      low_q <= low_q + 8'h01;
    end
  end

  // Wait for the line high, gap 16, low 128, one-cycle high, release.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy_q <= SY_IDLE;
      scnt_q <= 8'h00;
    end else begin
      scnt_q <= scnt_q + 8'h01;
      case (sy_q)
        SY_IDLE: begin
          scnt_q <= 8'h00;
          if (sync_o) begin
            sy_q <= SY_GAP;
          end
        end
        SY_GAP: begin
          if (scnt_q == bdcp_pkg::SYNC_GAP_CYC - 8'h01) begin
            sy_q <= SY_LOW;
            scnt_q <= 8'h00;
          end
        end
        SY_LOW: begin
          if (scnt_q == bdcp_pkg::SYNC_LOW_CYC - 8'h01) begin
            sy_q <= SY_HIGH;
          end
        end
        default: sy_q <= SY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else if (sy_q == SY_LOW || sy_q == SY_HIGH) begin
      out_q <= (sy_q == SY_HIGH);
      oe_n_q <= 1'b0;
    end else begin
      out_q <= drv_high_d;
      oe_n_q <= ~(drv_low_d | drv_high_d);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/bdcp_top.sv
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module bdcp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic debug_wire_pin_i,
  output logic debug_wire_pin_o,
  output logic debug_wire_pin_oe_n_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic cpu_halted_i,
  input wire logic [15:0] cpu_hx_i,
  input wire logic [15:0] cpu_reg_rdata_i,
  output var bdcp_pkg::bdcp_reg_e cpu_reg_sel_o,
  output logic cpu_reg_we_o,
  output logic [15:0] cpu_reg_wdata_o,
  output logic cpu_bgnd_req_o,
  output logic cpu_go_o,
  output logic cpu_step_o,
  output logic cpu_tag_en_o,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_access_i,
  input wire logic cpu_boundary_i,
  input wire logic cpu_exec_i,
  input wire logic [15:0] cpu_exec_addr_i,
  output logic brk_req_o,
  output logic ack_mode_o,
  output logic clk_select_o
);
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_WD, ST_DLY, ST_SS, ST_RD
  } bdcp_st_e;
  bdcp_st_e state_q, state_d;
  bdcp_st_e to_addr, to_wd, to_dly, to_ss, to_rd;
  logic [15:0] shreg_q, wd_w, addr_q, last_q, match_q, rdata_q, hx_inc;
  logic [15:0] addr_w, rd_src;
  logic [7:0] cmd_q, code_w, sreg_q, status_w;
  logic [4:0] bitcnt_q, dcnt_q, len_w;
  logic [31:0] ctrl_q;
  logic rx_valid, rx_bit, slot_done, sync_ev, timeout_ev;
  logic rx_st, tx_st, bit_ev, last_bit, field_done, dly_done;
  logic allowed, exec_w, abort_w, busy_w, load_ss, load_rd;
  logic d_vld, d_act, d_addr, d_wd, d_w16, d_dly, d_ss, d_rd, d_r16;
  logic d_reg, brk_en, force_or_tag_select, match_acc, match_exec, pend_q, brk_q;
  logic wb_hit, wb_wr_ctrl, wb_ack_q;
  logic [31:0] wb_rd_w, wb_dat_q;

  ////////////////////////////////////////////////////////////////////////////
  bdcp_bit_link u_link (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(ctrl_q[bdcp_pkg::CTRL_LINK_EN]),
    .busy_i(busy_w),
    .tx_en_i(tx_st),
    .tx_bit_i(shreg_q[15]),
    .pin_i(debug_wire_pin_i),
    .pin_o(debug_wire_pin_o),
    .pin_oe_n_o(debug_wire_pin_oe_n_o),
    .rx_valid_o(rx_valid),
    .rx_bit_o(rx_bit),
    .slot_done_o(slot_done),
    .sync_o(sync_ev),
    .timeout_o(timeout_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // While the code byte is still arriving, decode the byte being completed.
  assign wd_w = {shreg_q[14:0], rx_bit};
  assign code_w = (state_q == ST_CMD) ? wd_w[7:0] : cmd_q;

  // Every command is a subset of addr / wdata / delay / status / rdata.
  always_comb begin
    d_vld = 1'b1;
    d_act = 1'b0;
    d_addr = 1'b0;
    d_wd = 1'b0;
    d_w16 = 1'b0;
    d_dly = 1'b0;
    d_ss = 1'b0;
    d_rd = 1'b0;
    d_r16 = 1'b0;
    d_reg = 1'b0;
    case (code_w)
      bdcp_pkg::CMD_ACK_ON, bdcp_pkg::CMD_ACK_OFF,
      bdcp_pkg::CMD_BGND: d_dly = 1'b1;
      bdcp_pkg::CMD_STAT_RD: d_ss = 1'b1;
      bdcp_pkg::CMD_CTRL_WR: d_wd = 1'b1;
      bdcp_pkg::CMD_MEM_RD, bdcp_pkg::CMD_MEM_RD_S: begin
        d_addr = 1'b1;
        d_dly = 1'b1;
        d_ss = code_w[0];
        d_rd = 1'b1;
      end
      bdcp_pkg::CMD_MEM_LAST: begin
        d_ss = 1'b1;
        d_rd = 1'b1;
      end
      bdcp_pkg::CMD_MEM_WR, bdcp_pkg::CMD_MEM_WR_S: begin
        d_addr = 1'b1;
        d_wd = 1'b1;
        d_dly = 1'b1;
        d_ss = code_w[0];
      end
      bdcp_pkg::CMD_MATCH_RD: begin
        d_rd = 1'b1;
        d_r16 = 1'b1;
      end
      bdcp_pkg::CMD_MATCH_WR: begin
        d_wd = 1'b1;
        d_w16 = 1'b1;
      end
      bdcp_pkg::CMD_GO, bdcp_pkg::CMD_STEP, bdcp_pkg::CMD_RESUME_TAGGING_CMD: begin
        d_act = 1'b1;
        d_dly = 1'b1;
      end
      bdcp_pkg::CMD_RD_ACC, bdcp_pkg::CMD_RD_CCR, bdcp_pkg::CMD_RD_PC,
      bdcp_pkg::CMD_RD_HX, bdcp_pkg::CMD_RD_SP: begin
        d_act = 1'b1;
        d_dly = 1'b1;
        d_rd = 1'b1;
        d_reg = 1'b1;
        d_r16 = (code_w[3:0] > 4'h9);
      end
      bdcp_pkg::CMD_NEXT_RD, bdcp_pkg::CMD_NEXT_RD_S: begin
        d_act = 1'b1;
        d_dly = 1'b1;
        d_ss = code_w[0];
        d_rd = 1'b1;
      end
      bdcp_pkg::CMD_WR_ACC, bdcp_pkg::CMD_WR_CCR, bdcp_pkg::CMD_WR_PC,
      bdcp_pkg::CMD_WR_HX, bdcp_pkg::CMD_WR_SP: begin
        d_act = 1'b1;
        d_wd = 1'b1;
        d_dly = 1'b1;
        d_w16 = (code_w[3:0] > 4'h9);
      end
      bdcp_pkg::CMD_NEXT_WR, bdcp_pkg::CMD_NEXT_WR_S: begin
        d_act = 1'b1;
        d_wd = 1'b1;
        d_dly = 1'b1;
        d_ss = code_w[0];
      end
      default: d_vld = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  assign to_rd = d_rd ? ST_RD : ST_CMD;
  assign to_ss = d_ss ? ST_SS : to_rd;
  assign to_dly = d_dly ? ST_DLY : to_ss;
  assign to_wd = d_wd ? ST_WD : to_dly;
  assign to_addr = d_addr ? ST_ADDR : to_wd;
  assign allowed = d_vld & (~d_act | cpu_halted_i);
  assign rx_st = (state_q == ST_CMD) | (state_q == ST_ADDR)
    | (state_q == ST_WD);
  assign tx_st = (state_q == ST_SS) | (state_q == ST_RD);
  assign bit_ev = rx_st ? rx_valid : (tx_st & slot_done);
  assign len_w = (state_q == ST_ADDR) ? bdcp_pkg::LEN_WORD
    : (state_q == ST_WD && d_w16) ? bdcp_pkg::LEN_WORD
    : (state_q == ST_RD && d_r16) ? bdcp_pkg::LEN_WORD
    : bdcp_pkg::LEN_BYTE;
  assign last_bit = (bitcnt_q == len_w - 5'h01);
  assign field_done = bit_ev & last_bit;
  assign dly_done = (state_q == ST_DLY)
    & (dcnt_q == bdcp_pkg::DLY_CYC - 5'h01);
  assign abort_w = sync_ev | timeout_ev;
  assign busy_w = (state_q != ST_CMD) | (bitcnt_q != 5'h00);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CMD: state_d = field_done ? (allowed ? to_addr : ST_CMD) : ST_CMD;
      ST_ADDR: state_d = field_done ? to_wd : ST_ADDR;
      ST_WD: state_d = field_done ? to_dly : ST_WD;
      ST_DLY: state_d = dly_done ? to_ss : ST_DLY;
      ST_SS: state_d = field_done ? to_rd : ST_SS;
      ST_RD: state_d = field_done ? ST_CMD : ST_RD;
      default: state_d = ST_CMD;
    endcase
  end

  // The action fires once every host-supplied field is in, never earlier,
  // so an abort mid-command leaves memory and mode untouched.
  assign exec_w = field_done & rx_st & allowed & (state_d != ST_ADDR)
    & (state_d != ST_WD);
  assign load_ss = (state_d == ST_SS) & (state_q != ST_SS);
  assign load_rd = (state_d == ST_RD) & (state_q != ST_RD);
  assign hx_inc = cpu_hx_i + 16'h0001;
  // A read fires as the address completes, before addr_q holds it.
  assign addr_w = (state_q == ST_ADDR) ? wd_w : addr_q;
  // Register and match reads must not wait a cycle for rdata_q to load.
  assign rd_src = d_reg ? cpu_reg_rdata_i
    : (code_w == bdcp_pkg::CMD_MATCH_RD) ? match_q : rdata_q;
  assign brk_en = sreg_q[bdcp_pkg::SR_BRK_EN];
  assign force_or_tag_select = sreg_q[bdcp_pkg::SR_FTS];
  assign status_w = (sreg_q & bdcp_pkg::SR_WMASK)
    | ({7'h00, cpu_halted_i} << bdcp_pkg::SR_HALTED);

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_w) begin
      state_q <= ST_CMD;
      bitcnt_q <= 5'h00;
      dcnt_q <= 5'h00;
    end else begin
      state_q <= state_d;
      bitcnt_q <= field_done ? 5'h00 : bitcnt_q + {4'h0, bit_ev};
      dcnt_q <= (state_q == ST_DLY) ? dcnt_q + 5'h01 : 5'h00;
    end
  end

  // Fields shift MSB first in both directions.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg_q <= 16'h0000;
    end else if (load_ss) begin
      shreg_q <= {status_w, 8'h00};
    end else if (load_rd) begin
      shreg_q <= d_r16 ? rd_src : {rd_src[7:0], 8'h00};
    end else if (rx_st && rx_valid) begin
      shreg_q <= wd_w;
    end else if (tx_st && slot_done) begin
      shreg_q <= {shreg_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 8'h00;
      addr_q <= 16'h0000;
    end else if (field_done && state_q == ST_CMD) begin
      cmd_q <= wd_w[7:0];
    end else if (field_done && state_q == ST_ADDR) begin
      addr_q <= wd_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sreg_q <= bdcp_pkg::SR_RESET;
      match_q <= 16'h0000;
      last_q <= 16'h0000;
      ack_mode_o <= 1'b0;
      cpu_tag_en_o <= 1'b0;
      cpu_reg_sel_o <= bdcp_pkg::REG_ACC;
    end else if (exec_w) begin
      case (code_w)
        bdcp_pkg::CMD_ACK_ON: ack_mode_o <= 1'b1;
        bdcp_pkg::CMD_ACK_OFF: ack_mode_o <= 1'b0;
        bdcp_pkg::CMD_CTRL_WR:
          sreg_q <= wd_w[7:0] & bdcp_pkg::SR_WMASK;
        bdcp_pkg::CMD_MATCH_WR: match_q <= wd_w;
        bdcp_pkg::CMD_MEM_RD, bdcp_pkg::CMD_MEM_RD_S: last_q <= addr_w;
        bdcp_pkg::CMD_NEXT_RD, bdcp_pkg::CMD_NEXT_RD_S: last_q <= hx_inc;
        bdcp_pkg::CMD_GO, bdcp_pkg::CMD_STEP: cpu_tag_en_o <= 1'b0;
        bdcp_pkg::CMD_RESUME_TAGGING_CMD: cpu_tag_en_o <= 1'b1;
        default: cpu_tag_en_o <= cpu_tag_en_o;
      endcase
      case (code_w[3:0])
        4'h8: cpu_reg_sel_o <= bdcp_pkg::REG_ACC;
        4'h9: cpu_reg_sel_o <= bdcp_pkg::REG_CCR;
        4'hb: cpu_reg_sel_o <= bdcp_pkg::REG_PC;
        4'hf: cpu_reg_sel_o <= bdcp_pkg::REG_SP;
        default: cpu_reg_sel_o <= bdcp_pkg::REG_HX;
      endcase
    end
  end

  // One-cycle strobes towards the CPU core; memory requests hold to ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_go_o <= 1'b0;
      cpu_step_o <= 1'b0;
      cpu_bgnd_req_o <= 1'b0;
      cpu_reg_we_o <= 1'b0;
      cpu_reg_wdata_o <= 16'h0000;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
    end else begin
      cpu_go_o <= exec_w & ((code_w == bdcp_pkg::CMD_GO)
        | (code_w == bdcp_pkg::CMD_RESUME_TAGGING_CMD));
      cpu_step_o <= exec_w & (code_w == bdcp_pkg::CMD_STEP);
      cpu_bgnd_req_o <= exec_w & (code_w == bdcp_pkg::CMD_BGND)
        & sreg_q[bdcp_pkg::SR_ENTRY];
      cpu_reg_we_o <= exec_w & d_act & d_wd
        | exec_w & (code_w[7:1] == bdcp_pkg::CMD_NEXT_RD[7:1]);
      if (exec_w) begin
        cpu_reg_wdata_o <= (d_act & d_wd & (code_w[7:4] == 4'h4)) ? wd_w
          : hx_inc;
      end
      if (mem_req_o && mem_ack_i) begin
        mem_req_o <= 1'b0;
      end else if (exec_w && (d_rd && !d_reg && !d_r16
          || d_wd && (code_w[7] || code_w[6:4] == 3'h5))
          && code_w != bdcp_pkg::CMD_CTRL_WR
          && code_w != bdcp_pkg::CMD_MATCH_WR) begin
        mem_req_o <= 1'b1;
        mem_we_o <= d_wd;
        mem_wdata_o <= wd_w[7:0];
        mem_addr_o <= d_addr ? addr_w
          : (code_w == bdcp_pkg::CMD_MEM_LAST) ? last_q : hx_inc;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else if (mem_req_o && mem_ack_i) begin
      rdata_q <= {8'h00, mem_rdata_i};
    end else if (dly_done && d_reg) begin
      rdata_q <= cpu_reg_rdata_i;
    end else if (exec_w && code_w == bdcp_pkg::CMD_MATCH_RD) begin
      rdata_q <= match_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign match_acc = cpu_access_i & (cpu_addr_i == match_q);
  assign match_exec = cpu_exec_i & (cpu_exec_addr_i == match_q);

  always_ff @(posedge clk_i) begin
    if (rst_i || !brk_en || !force_or_tag_select) begin
      pend_q <= 1'b0;
      brk_q <= brk_en & ~force_or_tag_select & match_exec & ~rst_i;
    end else begin
      pend_q <= (pend_q | match_acc) & ~cpu_boundary_i;
      brk_q <= (pend_q | match_acc) & cpu_boundary_i;
    end
  end
  assign brk_req_o = brk_q;

  ////////////////////////////////////////////////////////////////////////////
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  assign wb_wr_ctrl = wb_hit & wb_we_i & wb_sel_i[0]
    & (wb_adr_i == bdcp_pkg::WB_CTRL_OFS);
  assign wb_rd_w = (wb_adr_i == bdcp_pkg::WB_CTRL_OFS) ? ctrl_q
    : (wb_adr_i == bdcp_pkg::WB_STAT_OFS)
    ? {19'h00000, ack_mode_o, brk_q, state_q, status_w} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= bdcp_pkg::CTRL_RESET;
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else begin
      wb_ack_q <= wb_hit;
      wb_dat_q <= wb_hit ? wb_rd_w : 32'h00000000;
      if (wb_wr_ctrl) begin
        ctrl_q <= {31'h00000000, wb_dat_i[bdcp_pkg::CTRL_LINK_EN]};
      end
    end
  end
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;
  assign clk_select_o = sreg_q[bdcp_pkg::SR_CLKSW];
endmodule
`default_nettype wire

// >>> testbench/bdcp_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bdcp_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic debug_wire_pin_o,
  input wire logic debug_wire_pin_oe_n_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic cpu_halted_i,
  input wire logic cpu_reg_we_o,
  input wire logic cpu_go_o,
  input wire logic cpu_step_o,
  input wire logic cpu_boundary_i,
  input wire logic cpu_exec_i,
  input wire logic brk_req_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic dlow, dhi, req;
  logic [7:0] lo_q;
  assign dlow = !debug_wire_pin_oe_n_o && !debug_wire_pin_o;
  assign dhi = !debug_wire_pin_oe_n_o && debug_wire_pin_o;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Counts how long we have been pulling the wire low.
  always_ff @(posedge clk_i) begin
    lo_q <= (dlow && !rst_i) ? lo_q + 8'h01 : 8'h00;
  end
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_wb_answer: assert property (req |=> s_ack)
    else $error("bus ack wrong");
  a_low_len: assert property ($fell(dlow) |->
    (lo_q == 8'h0d || lo_q == 8'h80) && dhi) else $error("low length");
  a_pulse_release: assert property (dhi |=> debug_wire_pin_oe_n_o)
    else $error("pulse not released");
  a_brk_single: assert property (brk_req_o |=> !brk_req_o)
    else $error("break not a pulse");
  a_brk_cause: assert property (brk_req_o |->
    $past(cpu_boundary_i) || $past(cpu_exec_i)) else $error("stray break");
  a_reg_halted: assert property (cpu_reg_we_o |-> $past(cpu_halted_i))
    else $error("register write while running");
  a_run_halted: assert property ((cpu_go_o || cpu_step_o) |->
    $past(cpu_halted_i)) else $error("run request while running");
  a_mem_hold: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o)) else $error("memory request dropped");
endmodule
bind bdcp_top bdcp_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .debug_wire_pin_o, .debug_wire_pin_oe_n_o, .mem_req_o,
  .mem_ack_i, .mem_addr_o, .cpu_halted_i, .cpu_reg_we_o, .cpu_go_o,
  .cpu_step_o, .cpu_boundary_i, .cpu_exec_i, .brk_req_o);
`default_nettype wire

// >>> testbench/bdcp_host.sv
`timescale 1ns/10ps
`default_nettype none
module bdcp_host (
  input wire logic clk_i,
  input wire logic wire_i,
  output logic low_o
);
  initial low_o = 1'b0;
  // A one is let go early so the device's speedup pulse never fights us.
  task automatic slot(input logic b, output logic s);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (i == 12) s = wire_i;
      low_o <= i < (b ? 3 : 15);
    end
  endtask
  task automatic field(input logic [23:0] v, input int n,
                       output logic [23:0] r);
    logic b;
    r = 24'h0;
    for (int k = n - 1; k >= 0; k--) begin
      slot(v[k], b);
      r = {r[22:0], b};
    end
  endtask
  task automatic sync(output int n);
    n = 0;
    @(posedge clk_i) low_o <= 1'b1;
    repeat (140) @(posedge clk_i);
    low_o <= 1'b0;
    repeat (300) begin
      @(posedge clk_i);
      if (!wire_i) n++;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/background_debug_command_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module background_debug_command_port_tb;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] wv;
    logic [4:0] nw;
    logic dly;
    logic [4:0] nr;
    logic [15:0] ev;
  } bdcp_row_s;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, debug_wire_pin_o, debug_wire_pin_oe_n_o, low, wire_lvl;
  logic mem_req_o, mem_we_o, mem_ack_i = 1'b0, cpu_halted_i = 1'b0;
  logic [15:0] mem_addr_o, cpu_addr_i = 16'h0, last_r, cpu_reg_wdata_o;
  logic [7:0] mem_wdata_o;
  logic [23:0] last_w, r;
  logic cpu_access_i = 1'b0, cpu_boundary_i = 1'b0, cpu_exec_i = 1'b0;
  logic cpu_reg_we_o, brk_req_o, ack_mode_o;
  int miscompares = 0, samples_checked = 0, cycles = 0, brks = 0, n;
  bdcp_row_s rows [11];
  always #25 clk_i = ~clk_i;
  // Open drain with pull-up: either party may pull low.
  assign wire_lvl = !low && (debug_wire_pin_oe_n_o || debug_wire_pin_o);
  bdcp_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .debug_wire_pin_i(wire_lvl), .debug_wire_pin_o, .debug_wire_pin_oe_n_o,
    .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
    .mem_rdata_i(mem_addr_o[7:0] ^ 8'h5a), .cpu_halted_i,
    .cpu_hx_i(16'h0100), .cpu_reg_rdata_i(16'hbeef), .cpu_reg_sel_o(),
    .cpu_reg_we_o, .cpu_reg_wdata_o, .cpu_bgnd_req_o(), .cpu_go_o(),
    .cpu_step_o(), .cpu_tag_en_o(), .cpu_addr_i, .cpu_access_i,
    .cpu_boundary_i, .cpu_exec_i, .cpu_exec_addr_i(cpu_addr_i), .brk_req_o,
    .ack_mode_o, .clk_select_o());
  bdcp_host host (.clk_i, .wire_i(wire_lvl), .low_o(low));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    mem_ack_i <= (mem_req_o === 1'b1) && !mem_ack_i;
    if (mem_req_o && mem_ack_i && mem_we_o) last_w <= {mem_addr_o, mem_wdata_o};
    if (cpu_reg_we_o === 1'b1) last_r <= cpu_reg_wdata_o;
    if (brk_req_o === 1'b1) brks <= brks + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] ev);
    samples_checked++;
    if (seen !== ev) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, ev);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] wv,
                     input int nw, input logic dly, input int nr);
    host.field({16'h0, op}, 8, r);
    if (nw != 0) host.field(wv, nw, r);
    if (dly) repeat (16) @(posedge clk_i);
    if (nr != 0) host.field(24'hffffff, nr, r);
  endtask
  task automatic hit(input logic [15:0] a, input logic f);
    @(posedge clk_i);
    cpu_addr_i <= a;
    cpu_access_i <= f;
    cpu_exec_i <= !f;
    @(posedge clk_i);
    cpu_access_i <= 1'b0;
    cpu_exec_i <= 1'b0;
    cpu_boundary_i <= f;
    @(posedge clk_i);
    cpu_boundary_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{8'hc4, 24'hb0, 5'h08, 1'b0, 5'h00, 16'h0},
      '{8'he4, 24'h0, 5'h00, 1'b0, 5'h08, 16'hf0},
      '{8'hc2, 24'h1234, 5'h10, 1'b0, 5'h00, 16'h0},
      '{8'he2, 24'h0, 5'h00, 1'b0, 5'h10, 16'h1234},
      '{8'he0, 24'h42, 5'h10, 1'b1, 5'h08, 16'h18},
      '{8'he1, 24'h43, 5'h10, 1'b1, 5'h10, 16'hf019},
      '{8'he8, 24'h0, 5'h00, 1'b0, 5'h10, 16'hf019},
      '{8'h6b, 24'h0, 5'h00, 1'b1, 5'h10, 16'hbeef},
      '{8'hc1, 24'h77a5, 5'h18, 1'b1, 5'h08, 16'hf0},
      '{8'h4c, 24'hc3d2, 5'h10, 1'b1, 5'h00, 16'h0},
      '{8'h10, 24'h0, 5'h00, 1'b1, 5'h00, 16'h0}};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check(rd[23:0], 24'h1);
    wb(1'b0, 4'h4, 32'h0);
    check(rd[23:0] & 24'hff, 24'h0);
    wb(1'b0, 4'h8, 32'h0);
    check(rd[23:0], 24'h0);
    wb(1'b1, 4'h0, 32'h1);
    cpu_halted_i <= 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].wv, rows[i].nw, rows[i].dly, rows[i].nr);
      if (rows[i].nr != 0) check(r, {8'h0, rows[i].ev});
    end
    check(last_w, 24'h0077a5);
    check({8'h0, last_r}, 24'hc3d2);
    cmd(8'hd5, 24'h0, 0, 1'b1, 0);
    check({23'h0, ack_mode_o}, 24'h1);
    cmd(8'hd6, 24'h0, 0, 1'b1, 0);
    check({23'h0, ack_mode_o}, 24'h0);
    cpu_halted_i <= 1'b0;
    cmd(8'h4c, 24'h0, 0, 1'b0, 0);
    cmd(8'h33, 24'h0, 0, 1'b0, 0);
    cmd(8'he4, 24'h0, 0, 1'b0, 8);
    check(r, 24'hb0);
    host.field(24'he, 4, r);
    repeat (600) @(posedge clk_i);
    cmd(8'he4, 24'h0, 0, 1'b0, 8);
    check(r, 24'hb0);
    hit(16'h1234, 1'b1);
    hit(16'h1235, 1'b1);
    check(brks[23:0], 24'h1);
    cmd(8'hc4, 24'ha0, 8, 1'b0, 0);
    hit(16'h1234, 1'b0);
    check(brks[23:0], 24'h2);
    cmd(8'hc4, 24'h80, 8, 1'b0, 0);
    hit(16'h1234, 1'b0);
    hit(16'h1234, 1'b1);
    check(brks[23:0], 24'h2);
    host.sync(n);
    check(n[23:0], 24'h80);
    tally_and_finish();
  end
endmodule
`default_nettype wire
